//--- logic/spec_exec_pkg.sv
// package: opcodes, field layout, reset values and carriers for the
// special-instruction execution unit
// assumes: included before the execution unit in compile order
package spec_exec_pkg;

    localparam logic [7:0] OP_JUMP_VIA_ACC   = 8'he0;
    localparam logic [7:0] OP_COPY_PC_TO_ACC = 8'hf0;
    localparam logic [7:0] OP_UNSIGNED_MUL   = 8'h01;
    localparam logic [7:0] OP_UNSIGNED_DIV   = 8'h11;
    localparam logic [7:0] OP_SWAP_ACC_PC    = 8'hf4;
    localparam logic [4:0] OP_VECTOR_CALL_HI = 5'h1d;
    localparam logic [7:0] OP_LOAD_ACC_IMM8  = 8'h04;
    localparam logic [7:0] OP_LOAD_ACC_EXT   = 8'h60;

    localparam int         VCT_LSB           = 0;
    localparam int         VCT_W             = 3;
    localparam logic [15:0] VECTOR_BASE      = 16'hffc0;

    localparam logic [15:0] RESET_PC         = 16'h0000;
    localparam logic [15:0] RESET_SP         = 16'h0100;
    localparam logic [15:0] RESET_WORD       = 16'h0000;
    localparam logic [3:0]  RESET_FLAGS      = 4'h0;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mem_req_s;

    typedef struct packed {
        logic [15:0] acc;
        logic [15:0] tmp;
        logic [15:0] pc;
        logic [15:0] sp;
        logic [3:0]  nzvc;
    } core_state_s;

endpackage

//--- logic/special_exec.sv
// special-instruction execution unit of an 8-bit core
// assumes: single-ported memory answering a read in the next cycle
// How it works
// - jump loads whole accumulator into pc
// - copy gives next instruction address
// - multiply low bytes, product to accumulator
// - multiply and divide keep flags
// - divide temporary by low byte
// - divide clears both high bytes
// - quotient overflow undefined, no indication
// - exchange swaps accumulator and pc
// - exchange leaves next address in accumulator
// - vector call pushes return, jumps via table
// - vector call is one byte
// - pushed address follows the call opcode
// - byte load copies old low byte to temporary
// - operand bytes consumed in written order
// - vector number is opcode field
// - accumulators are 16 bits, two halves
`timescale 1ns/1ps
`default_nettype none
module special_exec
    import spec_exec_pkg::*;
#(
    // entries in the vector table, one per value of the opcode field
    parameter int unsigned VECTOR_COUNT = 8
)
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // memory
    input  wire logic [7:0]  mem_rdata_i,
    output mem_req_s         mem_o,
    // visible state
    output core_state_s      state_o,
    output logic             fetch_o
);

    typedef enum logic [3:0] {
        S_FETCH, S_DECODE, S_OPND1, S_OPND2, S_LOADMEM,
        S_PUSH_HI, S_PUSH_LO, S_VEC_HI, S_VEC_LO, S_VEC_DONE
    } step_e;

    step_e       step_q, step_d;
    logic [15:0] acc_q, tmp_q, pc_q, sp_q;
    logic [15:0] acc_d, tmp_d, pc_d, sp_d;
    logic [3:0]  nzvc_q, nzvc_d;
    logic [7:0]  op_q, op_d, opnd_q, opnd_d;
    logic [15:0] vpc_q, vpc_d;
    mem_req_s    req_d, req_q;

    // the vector number is a three-bit opcode field, so eight entries
    if (VECTOR_COUNT != (1 << VCT_W)) begin : g_bad_vector_count
        $error("special_exec: VECTOR_COUNT must be eight");
    end

    wire logic [7:0]  acc_lo = acc_q[7:0];
    wire logic [7:0]  tmp_lo = tmp_q[7:0];
    wire logic [15:0] pc_inc = pc_q + 16'h0001;
    wire logic [15:0] product = {8'h00, acc_lo}
                              * {8'h00, tmp_lo};
    // zero divisor and oversize quotient give undefined result
    wire logic [15:0] quot  = (acc_lo == 8'h00) ? 16'hffff
                                                : tmp_q / {8'h00, acc_lo};
    wire logic [15:0] remd  = (acc_lo == 8'h00) ? tmp_q
                                                : tmp_q % {8'h00, acc_lo};
    wire logic        is_vcall = (mem_rdata_i[7:3] == OP_VECTOR_CALL_HI);
    wire logic [2:0]  vct = op_q[VCT_LSB +: VCT_W];
    wire logic [15:0] vec_addr = VECTOR_BASE | {12'h000, vct, 1'b0};
    wire logic [15:0] vec_addr_lo = vec_addr + 16'h0001;

    // stack addresses of the vector call
    wire logic [15:0] sp_call     = sp_q - 16'h0002;
    wire logic [15:0] push_lo_adr = sp_q + 16'h0001;

    // old low byte moves to temporary on a byte load
    wire logic [15:0] tmp_on_load = {tmp_q[15:8], acc_lo};
    wire logic [15:0] acc_loaded  = {acc_q[15:8], mem_rdata_i};

    // both high bytes end up zero after a divide
    wire logic [15:0] acc_div     = {8'h00, quot[7:0]};
    wire logic [15:0] tmp_div     = {8'h00, remd[7:0]};

    // opcode decode on the byte just fetched; anything else is a no-op
    wire logic        is_jump     = (mem_rdata_i == OP_JUMP_VIA_ACC);
    wire logic        is_copy     = (mem_rdata_i == OP_COPY_PC_TO_ACC);
    wire logic        is_mul      = (mem_rdata_i == OP_UNSIGNED_MUL);
    wire logic        is_div      = (mem_rdata_i == OP_UNSIGNED_DIV);
    wire logic        is_swap     = (mem_rdata_i == OP_SWAP_ACC_PC);
    wire logic        is_load_imm = (mem_rdata_i == OP_LOAD_ACC_IMM8);
    wire logic        is_load_ext = (mem_rdata_i == OP_LOAD_ACC_EXT);
    wire logic        op_imm      = (op_q == OP_LOAD_ACC_IMM8);

    always_comb begin
        step_d = step_q;
        acc_d  = acc_q;
        tmp_d  = tmp_q;
        pc_d   = pc_q;
        sp_d   = sp_q;
        nzvc_d = nzvc_q;
        op_d   = op_q;
        opnd_d = opnd_q;
        vpc_d  = vpc_q;
        req_d  = '0;
        unique case (step_q)
            S_FETCH: begin
                // opcode read; pc moves past the opcode at once
                req_d.rd   = 1'b1;
                req_d.addr = pc_q;
                pc_d       = pc_inc;
                step_d     = S_DECODE;
            end
            S_DECODE: begin
                op_d   = mem_rdata_i;
                step_d = S_FETCH;
                if (is_jump) begin
                    pc_d = acc_q;
                end else if (is_copy) begin
                    acc_d = pc_q;
                end else if (is_mul) begin
                    acc_d = product;
                end else if (is_div) begin
                    acc_d = acc_div;
                    tmp_d = tmp_div;
                end else if (is_swap) begin
                    pc_d  = acc_q;
                    acc_d = pc_q;
                end else if (is_vcall) begin
                    // no operand fetch; pc already past opcode
                    vpc_d  = pc_q;
                    sp_d   = sp_call;
                    step_d = S_PUSH_HI;
                end else if (is_load_imm || is_load_ext) begin
                    req_d.rd   = 1'b1;
                    req_d.addr = pc_q;
                    pc_d       = pc_inc;
                    step_d     = S_OPND1;
                end
            end
            S_OPND1: begin
                // first operand byte right after the opcode
                if (op_imm) begin
                    tmp_d  = tmp_on_load;
                    acc_d  = acc_loaded;
                    step_d = S_FETCH;
                end else begin
                    opnd_d     = mem_rdata_i;
                    req_d.rd   = 1'b1;
                    req_d.addr = pc_q;
                    pc_d       = pc_inc;
                    step_d     = S_OPND2;
                end
            end
            S_OPND2: begin
                // upper address byte first, lower second
                req_d.rd   = 1'b1;
                req_d.addr = {opnd_q, mem_rdata_i};
                step_d     = S_LOADMEM;
            end
            S_LOADMEM: begin
                tmp_d  = tmp_on_load;
                acc_d  = acc_loaded;
                step_d = S_FETCH;
            end
            S_PUSH_HI: begin
                req_d.wr    = 1'b1;
                req_d.addr  = sp_q;
                req_d.wdata = vpc_q[15:8];
                step_d      = S_PUSH_LO;
            end
            S_PUSH_LO: begin
                req_d.wr    = 1'b1;
                req_d.addr  = push_lo_adr;
                req_d.wdata = vpc_q[7:0];
                step_d      = S_VEC_HI;
            end
            S_VEC_HI: begin
                req_d.rd   = 1'b1;
                req_d.addr = vec_addr;
                step_d     = S_VEC_LO;
            end
            S_VEC_LO: begin
                req_d.rd   = 1'b1;
                req_d.addr = vec_addr_lo;
                opnd_d     = mem_rdata_i;
                step_d     = S_VEC_DONE;
            end
            S_VEC_DONE: begin
                pc_d   = {opnd_q, mem_rdata_i};
                step_d = S_FETCH;
            end
        endcase
    end

    // sequencer step
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            step_q <= S_FETCH;
        end else begin
            step_q <= step_d;
        end
    end

    // accumulator
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            acc_q <= RESET_WORD;
        end else begin
            acc_q <= acc_d;
        end
    end

    // temporary accumulator
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            tmp_q <= RESET_WORD;
        end else begin
            tmp_q <= tmp_d;
        end
    end

    // program counter
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pc_q <= RESET_PC;
        end else begin
            pc_q <= pc_d;
        end
    end

    // stack pointer
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            sp_q <= RESET_SP;
        end else begin
            sp_q <= sp_d;
        end
    end

    // condition flags, never touched here
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            nzvc_q <= RESET_FLAGS;
        end else begin
            nzvc_q <= nzvc_d;
        end
    end

    // opcode being executed
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            op_q <= 8'h00;
        end else begin
            op_q <= op_d;
        end
    end

    // first operand or vector high byte
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            opnd_q <= 8'h00;
        end else begin
            opnd_q <= opnd_d;
        end
    end

    // return address of a vector call
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            vpc_q <= RESET_WORD;
        end else begin
            vpc_q <= vpc_d;
        end
    end

    // memory request register
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            req_q <= '0;
        end else begin
            req_q <= req_d;
        end
    end

    // reset leaves the sequencer in the fetch step, so this starts high
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            fetch_o <= 1'b1;
        end else begin
            fetch_o <= (step_d == S_FETCH);
        end
    end

    // memory strobes and visible state straight from registers
    assign mem_o   = req_q;
    assign state_o = '{acc:  acc_q,
                       tmp:  tmp_q,
                       pc:   pc_q,
                       sp:   sp_q,
                       nzvc: nzvc_q};

endmodule // special_exec
`default_nettype wire

//--- testbench/mem_model.sv
// partner: byte memory for program, stack and vector table
// assumes: driven by special_exec, read data stands while the read does
`timescale 1ns/1ps
`default_nettype none
module mem_model
    import spec_exec_pkg::*;
(
    input  wire logic     clk_i,
    input  wire mem_req_s mem_i,
    output logic [7:0]    rdata_o
);
    logic [7:0] mem [0:65535];
    // data stands with the read strobe; idle bus shows the inverse
    assign rdata_o = mem_i.rd ? mem[mem_i.addr]
                              : ~mem[mem_i.addr];
    always @(posedge clk_i) begin
        if (mem_i.wr) begin
            mem[mem_i.addr] <= mem_i.wdata;
        end
    end
endmodule // mem_model
`default_nettype wire

//--- testbench/special_exec_assertions.sv
// checker: special instruction results at the ports
// assumes: bound into special_exec, memory answers next cycle
`timescale 1ns/1ps
`default_nettype none
module special_exec_assertions
    import spec_exec_pkg::*;
(
    // clock and reset
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    // watched ports
    input wire logic [7:0]  mem_rdata_i,
    input wire mem_req_s    mem_o,
    input wire core_state_s state_o,
    input wire logic        fetch_o
);
    logic        fq_q;
    logic [15:0] ret_q, spn_q, vad_q;
    wire  [7:0]  op = mem_rdata_i;
    wire  [15:0] acc = state_o.acc;
    wire  [15:0] tmp = state_o.tmp;
    // opcode stands on the read data while the fetch read is out
    wire         tk = fq_q && mem_o.rd;
    wire         vec = tk && op[7:3] == OP_VECTOR_CALL_HI;
    always_ff @(posedge clk_i) begin
        fq_q <= reset_n_i && fetch_o;
        if (vec) begin
            ret_q <= mem_o.addr + 16'h1;
            spn_q <= state_o.sp - 16'h2;
            vad_q <= VECTOR_BASE + {12'h0, op[2:0], 1'b0};
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_flags; $stable(state_o.nzvc); endproperty
    a_flags: assert property (p_flags) else $error("flags");
    property p_jump; tk && op == OP_JUMP_VIA_ACC |=>
        state_o.pc == $past(acc); endproperty
    a_jump: assert property (p_jump) else $error("jump");
    property p_copy; tk && op == OP_COPY_PC_TO_ACC |=>
        acc == $past(mem_o.addr) + 16'h1; endproperty
    a_copy: assert property (p_copy) else $error("copy");
    property p_mul; tk && op == OP_UNSIGNED_MUL |=> $stable(tmp) &&
        acc == $past(acc[7:0]) * $past(tmp[7:0]); endproperty
    a_mul: assert property (p_mul) else $error("mul");
    property p_div; tk && op == OP_UNSIGNED_DIV && tmp[15:8] < acc[7:0]
        |=> acc == $past(tmp) / $past(acc[7:0]) &&
        tmp == $past(tmp) % $past(acc[7:0]); endproperty
    a_div: assert property (p_div) else $error("div");
    property p_swap; tk && op == OP_SWAP_ACC_PC |=> state_o.pc ==
        $past(acc) && acc == $past(mem_o.addr) + 16'h1; endproperty
    a_swap: assert property (p_swap) else $error("swap");
    property p_push; vec |-> ##[1:4] (mem_o.wr && mem_o.addr == spn_q &&
        mem_o.wdata == ret_q[15:8]) ##1 (mem_o.wr && mem_o.wdata ==
        ret_q[7:0] && mem_o.addr == spn_q + 16'h1); endproperty
    a_push: assert property (p_push) else $error("push");
    property p_vrd; vec |-> ##[1:6] (mem_o.rd && mem_o.addr == vad_q)
        ##1 (mem_o.rd && mem_o.addr == vad_q + 16'h1); endproperty
    a_vrd: assert property (p_vrd) else $error("vector");
    c_div: cover property (tk && op == OP_UNSIGNED_DIV);
    c_vec: cover property (vec);
    c_jump: cover property (tk && op == OP_JUMP_VIA_ACC);
endmodule // special_exec_assertions
bind special_exec special_exec_assertions u_chk (.clk_i, .reset_n_i,
    .mem_rdata_i, .mem_o, .state_o, .fetch_o);
`default_nettype wire

//--- testbench/special_exec_test.sv
// testbench: runs a short program through the execution unit
// assumes: mem_model as memory, program placed before reset
`timescale 1ns/1ps
`default_nettype none
module special_exec_test;
    import spec_exec_pkg::*;
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [7:0]  rdata;
    mem_req_s    req;
    core_state_s st;
    int          miscompares = 0;
    int          check_count = 0;
    logic [7:0]  prog [12] = '{8'h04, 8'h12, 8'h04, 8'h34, 8'h01, 8'h60,
                               8'hff, 8'h80, 8'h11, 8'hf0, 8'hf4, 8'heb};
    always #20 clk_i = ~clk_i;
    special_exec u_dut (.clk_i, .reset_n_i, .mem_rdata_i(rdata),
                        .mem_o(req), .state_o(st), .fetch_o());
    mem_model u_mem (.clk_i, .mem_i(req), .rdata_o(rdata));
    task automatic cmp(string n, logic [15:0] e, logic [15:0] s);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // wait for the opcode read at a, then check acc and tmp under mask
    task automatic step(logic [15:0] a, ea, et, m);
        int n;
        n = 0;
        @(negedge clk_i);
        while (!(req.rd === 1'b1 && req.addr === a) && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        cmp("fetch", a, req.addr);
        cmp("acc", ea & m, st.acc & m);
        cmp("tmp", et & m, st.tmp & m);
    endtask
    task automatic t_byte_load;
        step(16'h0002, 16'h0012, 16'h0000, 16'hffff);
        step(16'h0004, 16'h0034, 16'h0012, 16'hffff);
    endtask
    task automatic t_mul_div;
        step(16'h0005, 16'h03a8, 16'h0012, 16'hffff);
        step(16'h0008, 16'h0005, 16'h00a8, 16'h00ff);
        step(16'h0009, 16'h0021, 16'h0003, 16'hffff);
        cmp("flags", 16'h0000, {12'h000, st.nzvc});
    endtask
    task automatic t_pc_ops;
        step(16'h000a, 16'h000a, 16'h0003, 16'hffff);
        step(16'h000a, 16'h000b, 16'h0003, 16'hffff);
        step(16'h000b, 16'h000b, 16'h0003, 16'hffff);
    endtask
    task automatic t_vector_jump;
        step(16'hfedc, 16'h000b, 16'h0003, 16'hffff);
        cmp("sp", 16'h00fe, st.sp);
        cmp("ret hi", 16'h0000, {8'h00, u_mem.mem[16'h00fe]});
        cmp("ret lo", 16'h000c, {8'h00, u_mem.mem[16'h00ff]});
        step(16'hfedd, 16'hfedd, 16'h0003, 16'hffff);
        step(16'hfedd, 16'hfedd, 16'h0003, 16'hffff);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        foreach (prog[i]) u_mem.mem[i] = prog[i];
        u_mem.mem[16'hff80] = 8'h05;
        u_mem.mem[16'hffc6] = 8'hfe;
        u_mem.mem[16'hffc7] = 8'hdc;
        u_mem.mem[16'hfedc] = 8'hf0;
        u_mem.mem[16'hfedd] = 8'he0;
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1'b1;
        step(16'h0000, 16'h0000, 16'h0000, 16'hffff);
        cmp("sp", 16'h0100, st.sp);
        t_byte_load();
        t_mul_div();
        t_pc_ops();
        t_vector_jump();
        report_and_stop();
    end
    initial begin
        repeat (2000) @(posedge clk_i);
        miscompares++;
        report_and_stop();
    end
endmodule // special_exec_test
`default_nettype wire
